// ---- rtl/xmsw_regs.svh ----
// register offsets, field positions, reset values and address map constants for the
// external memory sector/wait configuration block; definitions only
`ifndef XMSW_REGS_SVH
`define XMSW_REGS_SVH

// ----------------------------------------------------------------------
// register byte addresses (axi4-lite word aligned)
// ----------------------------------------------------------------------
`define XMSW_OFF_SECTOR_WAIT 4'h0
`define XMSW_OFF_KEEPER_MASK 4'h4
`define XMSW_OFF_PROC_CTRL 4'h8
`define XMSW_OFF_STATUS 4'hc

// ----------------------------------------------------------------------
// field positions, masks and reset values
// ----------------------------------------------------------------------
`define XMSW_SW_WMASK 8'h7e
`define XMSW_KM_WMASK 8'h87
`define XMSW_PC_WMASK 8'hc0
`define XMSW_SW_RESET 8'h00
`define XMSW_KM_RESET 8'h00
`define XMSW_PC_RESET 8'h00
`define XMSW_PC_ENABLE_BIT 7
`define XMSW_PC_UPPER_LO_BIT 6
`define XMSW_KM_KEEPER_BIT 7

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define XMSW_EXT_BASE 16'h1100
`define XMSW_EXT_BASE_LEGACY 16'h1000
`define XMSW_SECTOR_STEP 16'h2000

`endif

// ---- rtl/xmsw_pkg.sv ----
// types shared by the external memory sector/wait configuration block
// assumes the register header is compiled alongside
package xmsw_pkg;

	// wait code of one sector
	typedef enum logic [1:0] {
		XMSW_WAIT_NONE = 2'h0,
		XMSW_WAIT_ONE = 2'h1,
		XMSW_WAIT_TWO = 2'h2,
		XMSW_WAIT_TWO_GAP = 2'h3
	} xmsw_wait_t;

	// cpu data-space access request
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} xmsw_req_t;

	// pin drive towards the address latch and sram
	typedef struct packed {
		logic [7:0] ad_out;
		logic [7:0] ad_oe_n;
		logic [7:0] hi_addr;
		logic [7:0] hi_is_addr;
		logic ale;
		logic rd_n;
		logic wr_n;
	} xmsw_pins_t;

endpackage : xmsw_pkg

// ---- rtl/xmsw_cycle.sv ----
// one external memory access sequencer: ale, address, strobe stretch
// assumes a single request held until done; runs on the cpu clock
`timescale 1ns/10ps

module xmsw_cycle (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic external,
	input wire logic write,
	input wire xmsw_pkg::xmsw_wait_t wait_code,
	output logic ale,
	output logic addr_phase,
	output logic strobe,
	output logic busy,
	output logic done
);

	typedef enum {S_IDLE, S_ADDR, S_STROBE, S_GAP} xmsw_cyc_t;
	xmsw_cyc_t st_q;
	logic [1:0] cnt_q;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// strobe length is 1 + stretch; code 11 adds a gap before next address
	wire [1:0] stretch = (wait_code == xmsw_pkg::XMSW_WAIT_NONE) ? 2'h0 :
		(wait_code == xmsw_pkg::XMSW_WAIT_ONE) ? 2'h1 : 2'h2;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= S_IDLE;
			cnt_q <= 2'h0;
		end else begin
			unique case (st_q)
				S_IDLE: if (start) st_q <= S_ADDR;
				S_ADDR: begin
					st_q <= S_STROBE;
					cnt_q <= stretch;
				end
				S_STROBE: begin
					if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
					else if (wait_code == xmsw_pkg::XMSW_WAIT_TWO_GAP) st_q <= S_GAP;
					else st_q <= S_IDLE;
				end
				S_GAP: st_q <= S_IDLE;
			endcase
		end
	end

	// ale high in the address phase, low through the data transfer
	assign ale = (st_q == S_ADDR);
	assign addr_phase = (st_q == S_ADDR);
	// strobes only toggle for external accesses
	assign strobe = (st_q == S_STROBE) && external;
	assign busy = (st_q != S_IDLE);
	assign done = ((st_q == S_STROBE) && (cnt_q == 2'h0) &&
		(wait_code != xmsw_pkg::XMSW_WAIT_TWO_GAP)) || (st_q == S_GAP);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_gap_after_strobe;
		@(posedge clk) disable iff (!nrst)
		(st_q == S_STROBE && cnt_q == 2'h0 && wait_code == xmsw_pkg::XMSW_WAIT_TWO_GAP)
			|=> (st_q == S_GAP) ##1 (st_q == S_IDLE);
	endproperty
	a_gap_after_strobe: assert property (p_gap_after_strobe)
		else $error("no idle gap after wait code 11");

	property p_ale_before_strobe;
		@(posedge clk) disable iff (!nrst)
		(st_q == S_ADDR) |=> (st_q == S_STROBE && !ale);
	endproperty
	a_ale_before_strobe: assert property (p_ale_before_strobe)
		else $error("ale not low in data phase");

endmodule : xmsw_cycle

// ---- rtl/xmsw_top.sv ----
// external memory sector/wait configuration, address mapping and pin drive
// assumes an axi4-lite master for registers and a cpu data-space request port
`timescale 1ns/10ps
`include "xmsw_regs.svh"

module xmsw_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic legacy_mode,
	input wire xmsw_pkg::xmsw_req_t cpu_req,
	output logic cpu_done,
	output logic [7:0] cpu_rdata,
	input wire logic [7:0] port_hi_out,
	input wire logic [7:0] muxed_addr_data_lines_in,
	output xmsw_pkg::xmsw_pins_t pins_q
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] sector_wait_q;
	logic [7:0] keeper_mask_q;
	logic [7:0] proc_ctrl_q;
	logic [7:0] ad_sync1_q, ad_sync2_q;
	logic [7:0] keep_val_q;
	logic [15:0] addr_q;
	logic [7:0] wdata_q;
	logic write_q, ext_q, run_q;
	logic aw_q, w_q;
	logic [3:0] awaddr_q;
	logic [31:0] wdat_q;
	logic [1:0] rd_pipe_q;

	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	function automatic logic [7:0] xmsw_reg_read(input logic [3:0] a, input logic [7:0] sw,
		input logic [7:0] km, input logic [7:0] pc, input logic [7:0] st);
		xmsw_reg_read = (a == `XMSW_OFF_SECTOR_WAIT) ? sw :
			(a == `XMSW_OFF_KEEPER_MASK) ? km :
			(a == `XMSW_OFF_PROC_CTRL) ? pc :
			(a == `XMSW_OFF_STATUS) ? st : 8'h00;
	endfunction

	function automatic logic xmsw_mapped(input logic [3:0] a);
		xmsw_mapped = (a == `XMSW_OFF_SECTOR_WAIT) || (a == `XMSW_OFF_KEEPER_MASK) ||
			(a == `XMSW_OFF_PROC_CTRL) || (a == `XMSW_OFF_STATUS);
	endfunction

	wire enable = proc_ctrl_q[`XMSW_PC_ENABLE_BIT];
	wire keeper_on = keeper_mask_q[`XMSW_KM_KEEPER_BIT];
	wire [2:0] sector_limit = sector_wait_q[6:4];
	wire [2:0] high_mask = keeper_mask_q[2:0];
	// upper code straddles two registers
	wire [1:0] upper_code = {sector_wait_q[1], proc_ctrl_q[`XMSW_PC_UPPER_LO_BIT]};
	wire [1:0] lower_code = sector_wait_q[3:2];
	// boundary k*0x2000 is simply the top three address bits compared with k
	wire [15:0] boundary = {sector_limit, 13'h0000};
	wire in_lower = (sector_limit != 3'h0) && (addr_q < boundary);
	wire [1:0] sel_code = in_lower ? lower_code : upper_code;
	wire [15:0] ext_base = legacy_mode ? `XMSW_EXT_BASE_LEGACY : `XMSW_EXT_BASE;
	wire req_ext = (cpu_req.addr >= ext_base);
	// pins held by the address bus, mask releases from the top
	wire [7:0] hi_is_addr = (!enable || high_mask == 3'h7) ? 8'h00 : (8'hff >> high_mask);
	wire [7:0] status = {5'h00, in_lower, ext_q, run_q};
	wire wr_fire = aw_q && w_q && !s_axi_bvalid;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	// next states, so that the ready outputs can be flops of their own
	wire aw_d = (aw_q || aw_take) && !wr_fire;
	wire w_d = (w_q || w_take) && !wr_fire;
	wire bvalid_d = wr_fire || (s_axi_bvalid && !s_axi_bready);
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rvalid_d = rd_take || (s_axi_rvalid && !s_axi_rready);

	logic cyc_ale, cyc_addr, cyc_strobe, cyc_busy, cyc_done;

	xmsw_cycle u_cycle (
		.clk(clk),
		.nrst(nrst),
		.start(cpu_req.valid && enable && !run_q),
		.external(ext_q),
		.write(write_q),
		.wait_code(xmsw_pkg::xmsw_wait_t'(sel_code)),
		.ale(cyc_ale),
		.addr_phase(cyc_addr),
		.strobe(cyc_strobe),
		.busy(cyc_busy),
		.done(cyc_done)
	);

	// ----------------------------------------------------------------
	// axi4-lite write: address and data taken in either order
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdat_q <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			s_axi_bvalid <= bvalid_d;
			// ready stays low while a beat is held or the response waits
			s_axi_awready <= !aw_d && !bvalid_d;
			s_axi_wready <= !w_d && !bvalid_d;
			if (aw_take) awaddr_q <= s_axi_awaddr;
			if (w_take) wdat_q <= s_axi_wdata;
			if (wr_fire) s_axi_bresp <= xmsw_mapped(awaddr_q) ? 2'h0 : 2'h2;
		end
	end

	// register update; reserved bits never stored so they read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sector_wait_q <= `XMSW_SW_RESET;
			keeper_mask_q <= `XMSW_KM_RESET;
			proc_ctrl_q <= `XMSW_PC_RESET;
		end else if (wr_fire && awaddr_q == `XMSW_OFF_SECTOR_WAIT && wdat_q[7:0] != 8'h00) begin
			sector_wait_q <= wdat_q[7:0] & `XMSW_SW_WMASK;
		end else if (wr_fire && awaddr_q == `XMSW_OFF_SECTOR_WAIT) begin
			sector_wait_q <= 8'h00;
		end else if (wr_fire && awaddr_q == `XMSW_OFF_KEEPER_MASK) begin
			keeper_mask_q <= wdat_q[7:0] & `XMSW_KM_WMASK;
		end else if (wr_fire && awaddr_q == `XMSW_OFF_PROC_CTRL) begin
			proc_ctrl_q <= wdat_q[7:0] & `XMSW_PC_WMASK;
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read: one cycle after the address is taken
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_rvalid <= rvalid_d;
			s_axi_arready <= !rvalid_d; // one read at a time
			if (rd_take) begin
				s_axi_rdata <= {24'h0, xmsw_reg_read(s_axi_araddr, sector_wait_q,
					keeper_mask_q, proc_ctrl_q, status)};
				s_axi_rresp <= xmsw_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
			end
		end
	end

	// ----------------------------------------------------------------
	// access capture and pin synchroniser
	// ----------------------------------------------------------------
	// request held by the cpu; latched so the map cannot shift mid cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			run_q <= 1'b0;
			addr_q <= 16'h0;
			wdata_q <= 8'h0;
			write_q <= 1'b0;
			ext_q <= 1'b0;
		end else if (cpu_req.valid && enable && !run_q) begin
			run_q <= 1'b1;
			addr_q <= cpu_req.addr;
			wdata_q <= cpu_req.wdata;
			write_q <= cpu_req.write;
			ext_q <= req_ext;
		end else if (cyc_done) begin
			run_q <= 1'b0;
		end
	end

	// external bus lines come from a pin, so two flops first
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ad_sync1_q <= 8'h0;
			ad_sync2_q <= 8'h0;
		end else begin
			ad_sync1_q <= muxed_addr_data_lines_in;
			ad_sync2_q <= ad_sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// pin drive, all registered
	// ----------------------------------------------------------------
	// drive address in ale phase and write data during write strobe
	wire drive_addr = enable && run_q && (cyc_addr || !cyc_busy);
	wire drive_data = enable && run_q && write_q && cyc_busy && !cyc_addr;
	wire ad_drive = drive_addr || drive_data;
	wire [7:0] ad_val = drive_data ? wdata_q : addr_q[7:0];
	// keeper ignores the enable bit and holds the last driven byte
	wire [7:0] ad_hold = keeper_on ? keep_val_q : 8'h00;
	// read strobe about to rise: the pin value is still the sram's byte
	wire rd_end = !pins_q.rd_n && !(enable && cyc_strobe && !write_q);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pins_q <= '{ad_out: 8'h00, ad_oe_n: 8'hff, hi_addr: 8'h00, hi_is_addr: 8'h00,
				ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
			keep_val_q <= 8'h00;
			cpu_done <= 1'b0;
			cpu_rdata <= 8'h00;
			rd_pipe_q <= 2'h0;
		end else begin
			if (ad_drive) keep_val_q <= ad_val;
			pins_q.ad_out <= ad_drive ? ad_val : ad_hold;
			pins_q.ad_oe_n <= (ad_drive || keeper_on) ? 8'h00 : 8'hff;
			pins_q.hi_is_addr <= hi_is_addr;
			pins_q.hi_addr <= (addr_q[15:8] & hi_is_addr) | (port_hi_out & ~hi_is_addr);
			pins_q.ale <= enable && cyc_ale;
			pins_q.rd_n <= !(enable && cyc_strobe && !write_q);
			pins_q.wr_n <= !(enable && cyc_strobe && write_q);
			cpu_done <= cyc_done;
			// synchroniser lag: read data settles two cycles after the strobe ends
			rd_pipe_q <= {rd_pipe_q[0], rd_end};
			if (rd_pipe_q[1]) cpu_rdata <= ad_sync2_q;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_reserved_zero;
		@(posedge clk) disable iff (!nrst)
		(sector_wait_q[7] == 1'b0) && (sector_wait_q[0] == 1'b0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved sector bits set");

	property p_keeper_reserved;
		@(posedge clk) disable iff (!nrst)
		keeper_mask_q[6:3] == 4'h0;
	endproperty
	a_keeper_reserved: assert property (p_keeper_reserved)
		else $error("reserved keeper bits set");

	property p_one_sector;
		@(posedge clk) disable iff (!nrst)
		(sector_limit == 3'h0) |-> (sel_code == upper_code);
	endproperty
	a_one_sector: assert property (p_one_sector)
		else $error("limit zero did not use upper code");

	property p_lower_sel;
		@(posedge clk) disable iff (!nrst)
		(sector_limit != 3'h0 && addr_q[15:13] < sector_limit) |-> (sel_code == lower_code);
	endproperty
	a_lower_sel: assert property (p_lower_sel)
		else $error("lower sector code not selected");

	property p_no_strobe_internal;
		@(posedge clk) disable iff (!nrst)
		(run_q && !ext_q) |=> (pins_q.rd_n && pins_q.wr_n);
	endproperty
	a_no_strobe_internal: assert property (p_no_strobe_internal)
		else $error("strobe on internal access");

	property p_hi_mask;
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> (pins_q.hi_is_addr == ((!$past(enable) || $past(high_mask) == 3'h7) ? 8'h00 :
			(8'hff >> $past(high_mask))));
	endproperty
	a_hi_mask: assert property (p_hi_mask)
		else $error("high pin release wrong");

	property p_keeper_drive;
		@(posedge clk) disable iff (!nrst)
		(keeper_on && !ad_drive) |=> (pins_q.ad_oe_n == 8'h00 && pins_q.ad_out == $past(keep_val_q));
	endproperty
	a_keeper_drive: assert property (p_keeper_drive)
		else $error("keeper not holding last value");

	property p_disabled_pins;
		@(posedge clk) disable iff (!nrst)
		(!enable && !keeper_on) |=> (pins_q.ad_oe_n == 8'hff && pins_q.rd_n && pins_q.wr_n);
	endproperty
	a_disabled_pins: assert property (p_disabled_pins)
		else $error("pins driven while interface disabled");

endmodule : xmsw_top

// ---- verification/xmsw_sram_model.sv ----
// byte sram behind a transparent address latch, far side of the block
// assumes the package pin struct and the cpu clock of the block
`timescale 1ns/10ps

module xmsw_sram_model (
	input wire logic clk,
	input wire xmsw_pkg::xmsw_pins_t pins,
	input wire logic [7:0] port_hi,
	output logic [7:0] ad_in
);
	logic [7:0] mem [0:65535];
	logic [7:0] lat_q;
	logic [7:0] last_q;
	logic [15:0] addr;
	logic [7:0] dq;

	initial last_q = 8'h5a;

	// ----------------------------------------------------------------
	// address path
	// ----------------------------------------------------------------
	// latch holds what the lines carry at the edge that drops ale; sampling
	// on the clock avoids a race between ale and the data that follows it
	always @(posedge clk) begin
		if (pins.ale) lat_q <= pins.ad_out;
	end
	// released high pins carry the port value, not the address
	assign addr = {(pins.hi_is_addr & pins.hi_addr) | (~pins.hi_is_addr & port_hi), lat_q};
	assign dq = mem[addr];

	// ----------------------------------------------------------------
	// wire level and storage
	// ----------------------------------------------------------------
	// nobody driving: toggle the old level so a stale value never passes
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			ad_in[i] = !pins.ad_oe_n[i] ? pins.ad_out[i] : !pins.rd_n ? dq[i] : ~last_q[i];
		end
	end
	// store on every write strobe cycle, so the closing edge cannot race the data
	always @(posedge clk) begin
		last_q <= ad_in;
		if (!pins.wr_n) mem[addr] <= ad_in;
	end
endmodule : xmsw_sram_model

// ---- verification/test_ext_memory_sector_wait_config.sv ----
// self-checking bench: axi4-lite register tasks and cpu accesses
// assumes the sram model on the pins and a 25 mhz clock
`timescale 1ns/10ps

module test_ext_memory_sector_wait_config;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, cpu_done;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic legacy = 1'b0;
	logic [7:0] port_hi = 8'h00;
	logic [7:0] ad_in, cpu_rdata;
	xmsw_pkg::xmsw_req_t cpu_req = '0;
	xmsw_pkg::xmsw_pins_t pins;
	int fail_count = 0, samples_checked = 0, strobes = 0, lat, l0, s0;
	logic [31:0] d;
	logic [1:0] r;

	always #20 clk = ~clk;

	xmsw_top u_dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.legacy_mode(legacy), .cpu_req(cpu_req), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
		.port_hi_out(port_hi), .muxed_addr_data_lines_in(ad_in), .pins_q(pins));

	xmsw_sram_model u_mem (.clk(clk), .pins(pins), .port_hi(port_hi), .ad_in(ad_in));

	// strobe-low cycles of the access under way
	always @(negedge clk) begin
		if (!pins.rd_n || !pins.wr_n) strobes++;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// ready is looked at before the edge, so the edge itself decides the beat
	task automatic axw(input logic [3:0] a, input logic [31:0] v);
		logic ah, wh, ta, tw;
		ah = 1'b0;
		wh = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ah && wh)) begin
			@(negedge clk);
			ta = !ah && awready;
			tw = !wh && wready;
			@(posedge clk);
			if (ta) begin
				awvalid <= 1'b0;
				ah = 1'b1;
			end
			if (tw) begin
				wvalid <= 1'b0;
				wh = 1'b1;
			end
		end
		do @(negedge clk); while (!bvalid);
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [3:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
	endtask : axr

	// valid drops in the time step of the done edge, so no second start
	task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] v);
		realtime t0;
		@(posedge clk);
		cpu_req <= '{1'b1, w, a, v};
		t0 = $realtime;
		strobes = 0;
		@(posedge cpu_done);
		cpu_req.valid <= 1'b0;
		lat = int'(($realtime - t0) / 40.0);
		@(posedge clk);
	endtask : cpu

	// extra strobe cycles of a wait code, and gap counted when asked
	function automatic int ext(input int c, input bit gap);
		return (c == 3) ? (gap ? 3 : 2) : c;
	endfunction : ext

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 0; a < 12; a += 4) begin
			axr(a[3:0]);
			chk("reset value", 32'h0, d);
		end
		axw(4'h0, 32'hff);
		axr(4'h0);
		chk("sector_wait", 32'h7e, d);
		axw(4'h4, 32'hff);
		axr(4'h4);
		chk("keeper_mask", 32'h87, d);
		axr(4'h2);
		chk("unmapped resp", 32'h2, {30'h0, r});
		chk("unmapped data", 32'h0, d);
		axw(4'h2, 32'h1);
		chk("unmapped wresp", 32'h2, {30'h0, r});
		axw(4'h8, 32'h0);
		axw(4'h4, 32'h80);
		@(negedge clk);
		chk("keeper off iface", 32'h0, {24'h0, pins.ad_oe_n});
		axw(4'h4, 32'h0);
		@(negedge clk);
		chk("keeper off", 32'hff, {24'h0, pins.ad_oe_n});
		axw(4'h8, 32'h80);
		for (int m = 0; m < 8; m++) begin
			axw(4'h4, m);
			@(negedge clk);
			chk("hi_is_addr", (m == 7) ? 32'h0 : 32'hff >> m, {24'h0, pins.hi_is_addr});
		end
		axw(4'h8, 32'h0);
		@(negedge clk);
		chk("hi_is_addr off", 32'h0, {24'h0, pins.hi_is_addr});
		axw(4'h8, 32'h80);
		axw(4'h4, 32'h0);
		axw(4'h0, 32'h0);
		cpu(1'b1, 16'h1100, 8'h11);
		l0 = lat;
		s0 = strobes;
		chk("base strobes", 32'h1, {31'h0, s0 > 0});
		cpu(1'b0, 16'h10ff, 8'h0);
		chk("internal strobes", 0, strobes);
		legacy <= 1'b1;
		cpu(1'b1, 16'h1000, 8'h22);
		chk("legacy strobes", s0, strobes);
		legacy <= 1'b0;
		cpu(1'b1, 16'h1000, 8'h22);
		chk("nonlegacy strobes", 0, strobes);
		// lower code c below 0x4000, upper code 3-c from there on
		for (int c = 0; c < 4; c++) begin
			axw(4'h0, 32'h20 | (c << 2) | (((3 - c) >> 1) << 1));
			axw(4'h8, 32'h80 | (((3 - c) & 1) << 6));
			cpu(1'b1, 16'h3fff, c[7:0]);
			chk("lower latency", l0 + ext(c, 1), lat);
			chk("lower strobes", s0 + ext(c, 0), strobes);
			cpu(1'b1, 16'h4000, 8'h40);
			chk("upper latency", l0 + ext(3 - c, 1), lat);
			chk("upper strobes", s0 + ext(3 - c, 0), strobes);
			cpu(1'b0, 16'h3fff, 8'h0);
			// read data passes the pin synchroniser after the strobe
			repeat (3) @(negedge clk);
			chk("read data", c, cpu_rdata);
		end
		axw(4'h0, 32'h0e);
		axw(4'h8, 32'h80);
		cpu(1'b1, 16'h1100, 8'h33);
		chk("one sector latency", l0 + 2, lat);
		axw(4'h0, 32'h0);
		axw(4'h4, 32'h3);
		cpu(1'b1, 16'h2001, 8'haa);
		axw(4'h4, 32'h0);
		cpu(1'b1, 16'h2001, 8'h55);
		// 32 kb part without a15: top pin released, 0x8000 up aliases the bottom
		axw(4'h4, 32'h1);
		cpu(1'b1, 16'h8002, 8'h77);
		@(negedge clk);
		chk("alias low location", 32'h77, u_mem.mem[16'h0002]);
		chk("low 8k location", 32'haa, u_mem.mem[16'h0001]);
		chk("high location", 32'h55, u_mem.mem[16'h2001]);
		summarize();
	end

	// watchdog well beyond the few hundred cycles the tests need
	initial begin
		#(40 * 20000);
		fail_count++;
		summarize();
	end
endmodule : test_ext_memory_sector_wait_config
